// ---- verilog/srt_rx_test.v ----
// Serial receiver framing, 8b/10b decode, mode select and built-in self-test checker with APB registers.
// Notes on behaviour
// - Enable low starts checking; strobe low on init.
// - Self-test mismatch raises violation flag that byte.
// - Strobe pulses high once per self-test loop.
// - Self-test outputs show the expected pattern.
// - Enable high ends self-test, normal receive resumes.
// - Deliberate loop violations each pulse violation flag.
// - Bypass plus self-test switches to encoded checking.
// - Enable high in bypass restores raw operation.
// - Self-test behaves identically in factory test mode.
// - Mode high passes raw ten bits out.
// - Mode low decodes byte, violation, special flag.
// - Factory test mode uses external bit clock.
// - Strobe falling marks boundary after comma input.
// - Test outputs may show internal states.
// - Ten bits form one character, then decode.
// - Byte bit 0 is A; i,j derived.
// - Names Dxx.y or Kxx.y from special flag.
// - Comma resets bit counter only when reframing.
`include "srt_map.vh"
module srt_rx_test #(
  parameter [15:0] LOOP_LEN = `SRT_BIST_LOOP_LEN
)(
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire serial_data_i,
  input wire rx_bit_valid_i,
  input wire test_bit_clock_input_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  output reg [7:0] decoded_byte_out_o,
  output reg special_char_indicator_o,
  output reg receive_violation_flag_o,
  output reg [9:0] raw_symbol_out_o,
  output reg byte_valid_n_o
);

  // Primary (negative disparity) 6-bit codes; entry x sits at bits 6x+5..6x, with bit a most significant.
  localparam [191:0] CODE6 = {6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, 6'h33,
    6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B,
    6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39,
    6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27};

  // Primary 4-bit codes in order f..j.
  function [3:0] tab4;
    input [2:0] y;
    begin
      case (y)
        3'h0: tab4 = 4'b1011;
        3'h1: tab4 = 4'b1001;
        3'h2: tab4 = 4'b0101;
        3'h3: tab4 = 4'b1100;
        3'h4: tab4 = 4'b1101;
        3'h5: tab4 = 4'b1010;
        3'h6: tab4 = 4'b0110;
        default: tab4 = 4'b1110;
      endcase
    end
  endfunction

  function [2:0] ones;
    input [5:0] v;
    integer n;
    begin
      ones = 3'h0;
      for (n = 0; n < 6; n = n + 1)
        ones = ones + {2'h0, v[n]};
    end
  endfunction

  reg [3:0] ctrl_q;
  reg [9:0] shift_q;
  reg [3:0] bit_cnt_q;
  reg [9:0] sym_q;
  reg sym_stb_q;
  reg tclk_q;
  reg reframe_q;
  reg wait_frame_q;
  reg rd_q;
  reg bist_act_q;
  reg bist_sync_q;
  reg [15:0] pos_q;
  reg [7:0] lfsr_q;
  reg [15:0] err_cnt_q;
  reg [15:0] loop_cnt_q;
  reg strobe_hi_q;

  wire [1:0] mode = ctrl_q[`SRT_CTRL_MODE_MSB:`SRT_CTRL_MODE_LSB];
  wire st_en_n = ctrl_q[`SRT_CTRL_STEN_N_BIT];
  wire reframe = ctrl_q[`SRT_CTRL_REFRAME_BIT];
  // The external clock pin is sampled; one bit is taken on each of its rising edges.
  wire bit_stb = (mode == `SRT_MODE_TEST) ? (test_bit_clock_input_i & ~tclk_q) : rx_bit_valid_i;
  wire [9:0] shift_d = {serial_data_i, shift_q[9:1]};
  wire comma = (shift_d == `SRT_COMMA_NEG) || (shift_d == `SRT_COMMA_POS);
  wire resync = reframe & comma;
  wire char_done = bit_stb & ((bit_cnt_q == `SRT_BIT_LAST) | resync);
  wire enc_mode = bist_act_q | (mode != `SRT_MODE_BYPASS);
  wire [7:0] lfsr_next = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  wire pos_last = (pos_q == LOOP_LEN - 16'h0001);

  // Decoder: each sub-block is matched against its code or its complement.
  reg [5:0] c6;
  reg [3:0] c4;
  reg [3:0] c4m;
  reg [4:0] x5;
  reg [2:0] y3;
  reg f6;
  reg f4;
  reg k28;
  reg alt7;
  reg [2:0] o6;
  reg [2:0] o4;
  reg rd6;
  reg rd_d;
  reg dis_err;
  reg dec_k;
  reg dec_viol;
  reg [5:0] t6;
  reg [3:0] t4;
  integer k;
  always @*
  begin
    c6 = {sym_q[0], sym_q[1], sym_q[2], sym_q[3], sym_q[4], sym_q[5]};
    c4 = {sym_q[6], sym_q[7], sym_q[8], sym_q[9]};
    k28 = (c6 == `SRT_K28_NEG6) || (c6 == `SRT_K28_POS6);
    c4m = (c6 == `SRT_K28_POS6) ? ~c4 : c4;
    alt7 = (c4m == `SRT_ALT7_NEG) || (c4m == `SRT_ALT7_POS);
    x5 = k28 ? 5'h1C : 5'h00;
    f6 = k28;
    y3 = 3'h7;
    f4 = alt7;
    t6 = 6'h00;
    t4 = 4'h0;
    for (k = 0; k < 32; k = k + 1)
    begin
      t6 = CODE6[6 * k +: 6];
      if ((c6 == t6) || ((c6 == ~t6) && ((k == 7) || (ones(t6) != 3'h3))))
      begin
        x5 = k[4:0];
        f6 = 1'b1;
      end
    end
    for (k = 0; k < 8; k = k + 1)
    begin
      t4 = tab4(k[2:0]);
      if ((c4m == t4) || ((c4m == ~t4) && ((k == 3) || (ones({2'h0, t4}) != 3'h2))))
      begin
        y3 = k[2:0];
        f4 = 1'b1;
      end
    end
    o6 = ones(c6);
    o4 = ones({2'h0, c4});
    dis_err = (o6 > 3'h4) || (o6 < 3'h2) || ((o6 > 3'h3) && rd_q) || ((o6 < 3'h3) && !rd_q);
    if (o6 != 3'h3)
      rd6 = (o6 > 3'h3);
    else if (c6 == `SRT_BAL6_POS)
      rd6 = 1'b1;
    else if (c6 == `SRT_BAL6_NEG)
      rd6 = 1'b0;
    else
      rd6 = rd_q;
    dis_err = dis_err | (o4 > 3'h3) | (o4 < 3'h1) | ((o4 > 3'h2) && rd6) | ((o4 < 3'h2) && !rd6);
    if (o4 != 3'h2)
      rd_d = (o4 > 3'h2);
    else if (c4 == `SRT_BAL4_POS)
      rd_d = 1'b1;
    else if (c4 == `SRT_BAL4_NEG)
      rd_d = 1'b0;
    else
      rd_d = rd6;
    // Special flag selects the K name, data names follow EDCBA.HGF.
    dec_k = k28 | (alt7 & f6 & ((x5 == 5'h17) || (x5 == 5'h1B) || (x5 == 5'h1D) || (x5 == 5'h1E)));
    dec_viol = ~(f6 & f4) | dis_err;
  end

  wire [7:0] dec_byte = {y3, x5};
  wire [7:0] exp_byte = (pos_q == 16'h0000) ? `SRT_BIST_INIT_BYTE : lfsr_q;
  wire exp_k = (pos_q == 16'h0000);
  wire exp_viol = (pos_q != 16'h0000) && ((lfsr_q & `SRT_BIST_VIOL_MASK) == `SRT_BIST_VIOL_MASK);
  // Deliberate violations always flag, as do received violations and any mismatch.
  wire bist_flag = exp_viol | dec_viol | (dec_byte != exp_byte) | (dec_k != exp_k);
  wire init_seen = (dec_byte == `SRT_BIST_INIT_BYTE) & dec_k & ~dec_viol;

  wire apb_wr = psel_i & penable_i & pready_o & pwrite_i;
  wire addr_ok = (paddr_i == `SRT_ADDR_CTRL) || (paddr_i == `SRT_ADDR_STATUS) ||
                 (paddr_i == `SRT_ADDR_ERRCNT) || (paddr_i == `SRT_ADDR_LOOPCNT);
  reg [31:0] rdata;
  always @*
  begin
    case (paddr_i)
      `SRT_ADDR_CTRL: rdata = {28'h0000000, ctrl_q};
      `SRT_ADDR_STATUS: rdata = {27'h0, enc_mode, rd_q, wait_frame_q, bist_sync_q, bist_act_q};
      `SRT_ADDR_ERRCNT: rdata = {16'h0000, err_cnt_q};
      `SRT_ADDR_LOOPCNT: rdata = {16'h0000, loop_cnt_q};
      default: rdata = 32'h00000000;
    endcase
  end

  // Clock enable low freezes every flip-flop, bus answers included.
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      ctrl_q <= `SRT_CTRL_RESET;
    end
    else if (ce_i)
    begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~addr_ok;
      if (psel_i && !penable_i)
        prdata_o <= rdata;
      if (apb_wr && (paddr_i == `SRT_ADDR_CTRL))
        ctrl_q <= pwdata_i[3:0];
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      shift_q <= 10'h000;
      bit_cnt_q <= 4'h0;
      sym_q <= 10'h000;
      sym_stb_q <= 1'b0;
      tclk_q <= 1'b0;
      reframe_q <= 1'b0;
      wait_frame_q <= 1'b0;
    end
    else if (ce_i)
    begin
      tclk_q <= test_bit_clock_input_i;
      reframe_q <= reframe;
      sym_stb_q <= char_done;
      if (bit_stb)
      begin
        shift_q <= shift_d;
        if (char_done)
          bit_cnt_q <= 4'h0;
        else
          bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      if (char_done)
        sym_q <= shift_d;
      // Outside self-test the strobe stays off after reframing is enabled until a comma fixes the boundary.
      if (bit_stb && resync)
        wait_frame_q <= 1'b0;
      else if (reframe && !reframe_q)
        wait_frame_q <= 1'b1;
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_q <= 1'b0;
      bist_act_q <= 1'b0;
      bist_sync_q <= 1'b0;
      pos_q <= 16'h0000;
      lfsr_q <= `SRT_BIST_SEED;
      err_cnt_q <= 16'h0000;
      loop_cnt_q <= 16'h0000;
      strobe_hi_q <= 1'b0;
      decoded_byte_out_o <= 8'h00;
      special_char_indicator_o <= 1'b0;
      receive_violation_flag_o <= 1'b0;
      raw_symbol_out_o <= 10'h000;
      byte_valid_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      bist_act_q <= ~st_en_n;
      if (st_en_n)
        bist_sync_q <= 1'b0;
      if (apb_wr && (paddr_i == `SRT_ADDR_ERRCNT))
        err_cnt_q <= 16'h0000;
      if (apb_wr && (paddr_i == `SRT_ADDR_LOOPCNT))
        loop_cnt_q <= 16'h0000;
      strobe_hi_q <= 1'b0;
      if (sym_stb_q)
      begin
        rd_q <= rd_d;
        if (enc_mode)
        begin
          decoded_byte_out_o <= dec_byte;
          special_char_indicator_o <= dec_k;
          receive_violation_flag_o <= dec_viol;
        end
        else
          raw_symbol_out_o <= sym_q;
        if (bist_act_q && bist_sync_q)
        begin
          decoded_byte_out_o <= exp_byte;
          special_char_indicator_o <= exp_k;
          receive_violation_flag_o <= bist_flag;
          if (bist_flag && (err_cnt_q != 16'hFFFF))
            err_cnt_q <= err_cnt_q + 16'h0001;
          lfsr_q <= (pos_q == 16'h0000) ? `SRT_BIST_SEED : lfsr_next;
          if (pos_last)
          begin
            pos_q <= 16'h0000;
            strobe_hi_q <= 1'b1;
            loop_cnt_q <= loop_cnt_q + 16'h0001;
          end
          else
            pos_q <= pos_q + 16'h0001;
        end
        else if (bist_act_q && init_seen)
        begin
          // The init character counts as position zero of the loop.
          bist_sync_q <= 1'b1;
          pos_q <= 16'h0001;
          lfsr_q <= `SRT_BIST_SEED;
        end
      end
      if (bist_act_q)
        byte_valid_n_o <= ~(bist_sync_q | (sym_stb_q & init_seen)) | (sym_stb_q & bist_sync_q & pos_last);
      else
        byte_valid_n_o <= ~(sym_stb_q & ~wait_frame_q);
      if (strobe_hi_q && bist_sync_q && bist_act_q)
        byte_valid_n_o <= 1'b0;
    end
  end
endmodule

// ---- verilog/srt_map.vh ----
// Register offsets, field positions, reset values and code constants of the serial receiver test block.
`ifndef SRT_MAP_VH
`define SRT_MAP_VH
`define SRT_ADDR_CTRL 12'h000
`define SRT_ADDR_STATUS 12'h004
`define SRT_ADDR_ERRCNT 12'h008
`define SRT_ADDR_LOOPCNT 12'h00C
`define SRT_CTRL_MODE_LSB 0
`define SRT_CTRL_MODE_MSB 1
`define SRT_CTRL_STEN_N_BIT 2
`define SRT_CTRL_REFRAME_BIT 3
`define SRT_CTRL_RESET 4'h4
`define SRT_MODE_ENCODED 2'h0
`define SRT_MODE_BYPASS 2'h1
`define SRT_MODE_TEST 2'h2
`define SRT_BIT_LAST 4'h9
`define SRT_COMMA_NEG 10'h17C
`define SRT_COMMA_POS 10'h283
`define SRT_K28_NEG6 6'h0F
`define SRT_K28_POS6 6'h30
`define SRT_BAL6_POS 6'h07
`define SRT_BAL6_NEG 6'h38
`define SRT_BAL4_POS 4'h3
`define SRT_BAL4_NEG 4'hC
`define SRT_ALT7_NEG 4'h7
`define SRT_ALT7_POS 4'h8
`define SRT_BIST_INIT_BYTE 8'h3C
`define SRT_BIST_SEED 8'h01
`define SRT_BIST_VIOL_MASK 8'h1F
`define SRT_BIST_LOOP_LEN 16'h0100
`endif

// ---- verif/srt_rx_test_props.sv ----
// Port-level assertions for the serial receiver test block.
module srt_rx_test_props #(
  parameter [15:0] LOOP_LEN = 16'h0100
)(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic rx_bit_valid_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [7:0] decoded_byte_out_o,
  input wire logic special_char_indicator_o,
  input wire logic [9:0] raw_symbol_out_o,
  input wire logic byte_valid_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ctrl_q;
  logic st;
  logic byp;
  // The control word is mirrored from bus writes, so mode checks need no probes inside.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ctrl_q <= 4'h4;
    else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h000)
      ctrl_q <= pwdata_i[3:0];
  end
  assign st = !ctrl_q[2];
  assign byp = ctrl_q[1:0] == 2'h1 && ctrl_q[2];
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence setup_s;
    psel_i && !penable_i && ce_i;
  endsequence
  sequence enc2_s;
    !byp ##1 !byp;
  endsequence
  sequence byp2_s;
    byp ##1 byp;
  endsequence
  ready_next_a: assert property (setup_s |=> pready_o)
    else $error("no ready after setup");
  ready_once_a: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  unmapped_err_a: assert property (setup_s ##0 (!pwrite_i && paddr_i[11:4] != 8'h00) |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped read not refused");
  bit_strobe_a: assert property ($fell(byte_valid_n_o) && ctrl_q[2] && ctrl_q[1:0] != 2'h2 |-> $past(rx_bit_valid_i, 2))
    else $error("strobe not tied to a received bit");
  enc_raw_hold_a: assert property (enc2_s |-> $stable(raw_symbol_out_o))
    else $error("raw output moved outside bypass");
  byp_dec_hold_a: assert property (byp2_s |-> $stable(decoded_byte_out_o) && $stable(special_char_indicator_o))
    else $error("decoded output moved in bypass");
  loop_pulse_a: assert property (st ##1 (st && $rose(byte_valid_n_o)) |=> !byte_valid_n_o)
    else $error("loop pulse longer than one cycle");
  init_seen_a: assert property (st && $fell(byte_valid_n_o) && $past(byte_valid_n_o, 2) |-> decoded_byte_out_o == 8'h3C && special_char_indicator_o)
    else $error("self-test strobe fell without init code");
endmodule

// ---- verif/srt_link_tx.sv ----
// Link transmitter model: sends raw ten-bit characters, bit a first.
module srt_link_tx (
  input wire logic clk_i,
  input wire logic tm_i,
  input wire logic go_i,
  input wire logic [9:0] sym_i,
  output logic sd_o,
  output logic bv_o,
  output logic tck_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] sh = 10'h000;
  logic [5:0] ph = 6'h00;
  initial {sd_o, bv_o, tck_o, busy_o} = 4'h0;
  // Four cycles a bit leave room for a synchroniser on the test clock.
  always @(posedge clk_i)
  begin
    bv_o <= 1'b0;
    if (!busy_o)
    begin
      busy_o <= go_i;
      sh <= sym_i;
      ph <= 6'h00;
    end
    else
    begin
      ph <= ph + 6'h01;
      if (ph[1:0] == 2'h0)
      begin
        sd_o <= sh[0];
        sh <= sh >> 1;
        bv_o <= !tm_i;
        tck_o <= tm_i;
      end
      if (ph[1:0] == 2'h2)
        tck_o <= 1'b0;
      // The released line does not keep the last bit.
      if (ph == 6'h27)
      begin
        busy_o <= 1'b0;
        sd_o <= ~sd_o;
      end
    end
  end
endmodule

// ---- verif/srt_rx_test_tb.sv ----
// Self-checking bench for the serial receiver test block.
`include "srt_map.vh"
module srt_rx_test_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] D52 = 10'h2A5;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic serial_data_i, rx_bit_valid_i, test_bit_clock_input_i, go = 1'b0, tm = 1'b0, busy, perr;
  logic pready_o, pslverr_o, special_char_indicator_o, receive_violation_flag_o, byte_valid_n_o;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [7:0] decoded_byte_out_o;
  logic [9:0] raw_symbol_out_o, sym = 10'h000;
  wire [9:0] outs = {decoded_byte_out_o, special_char_indicator_o, receive_violation_flag_o};
  int bad_count = 0, n_checks = 0, cyc = 0, n_low = 0, n_hi = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  srt_rx_test #(.LOOP_LEN(16'h0002)) uut (.*);
  srt_link_tx tx (.clk_i(clk_sys_i), .tm_i(tm), .go_i(go), .sym_i(sym), .sd_o(serial_data_i),
    .bv_o(rx_bit_valid_i), .tck_o(test_bit_clock_input_i), .busy_o(busy));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc = cyc + 1;
    n_low <= n_low + (byte_valid_n_o === 1'b0 ? 1 : 0);
    n_hi <= n_hi + (byte_valid_n_o === 1'b1 ? 1 : 0);
    if (cyc == 6000)
    begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic ctl(input logic [3:0] c);
    apb(1'b1, `SRT_ADDR_CTRL, {28'h0, c});
    tm <= c[1:0] == 2'h2;
  endtask
  task automatic send(input logic [9:0] s);
    sym <= s;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    do @(posedge clk_sys_i); while (busy === 1'b1);
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic t_regs;
    apb(1'b0, `SRT_ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h4, rd);
    ctl(4'h7);
    apb(1'b0, `SRT_ADDR_CTRL, 32'h0);
    chk("ctrl rw", 32'h7, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {32'h1}, {rd[30:0], perr});
    ctl(4'h4);
  endtask
  task automatic t_enc;
    int n;
    n = n_low;
    send(D52);
    chk("strobe", n + 1, n_low);
    chk("d5.2", {3'h2, 5'h05, 2'h0}, outs);
    send(10'h3FF);
    chk("violation", 32'h1, {31'h0, receive_violation_flag_o});
    send(`SRT_COMMA_POS);
    chk("k28.5", {3'h5, 5'h1C, 1'h1}, outs[9:1]);
  endtask
  task automatic t_bist;
    int h;
    ctl(4'h0);
    // This violation leaves the running disparity negative, so the init character that follows stays legal.
    send(10'h23F);
    chk("pre-test violation", 32'h1, {31'h0, receive_violation_flag_o});
    send(D52);
    chk("await init", 32'h1, {31'h0, byte_valid_n_o});
    send(10'h27C);
    chk("init", {8'h3C, 2'h2}, outs);
    chk("synced", 32'h0, {31'h0, byte_valid_n_o});
    h = n_hi;
    send(D52);
    chk("loop pulse", h + 1, n_hi);
    chk("expected", {8'h01, 2'h1}, outs);
    apb(1'b0, `SRT_ADDR_LOOPCNT, 32'h0);
    chk("loops", 32'h1, rd);
    apb(1'b0, `SRT_ADDR_ERRCNT, 32'h0);
    chk("errors", 32'h1, rd);
    ctl(4'h4);
    // The held self-test strobe needs two more cycles to let go, so those low cycles stay out of the count.
    repeat (2) @(posedge clk_sys_i);
    h = n_low;
    send(D52);
    chk("resume", {h + 1, 10'h114}, {n_low, outs});
  endtask
  task automatic t_bbist;
    ctl(4'h5);
    send(D52);
    chk("raw", D52, raw_symbol_out_o);
    ctl(4'h1);
    send(10'h183);
    chk("bypass init", {8'h3C, 2'h2}, outs);
    ctl(4'h5);
    send(10'h27C);
    chk("raw again", 10'h27C, raw_symbol_out_o);
  endtask
  task automatic t_tmode;
    int n;
    ctl(4'h6);
    n = n_low;
    send(D52);
    chk("test clock", {n + 1, 8'h45}, {n_low, decoded_byte_out_o});
    ctl(4'hE);
    n = n_low;
    send(D52);
    chk("suppressed", n, n_low);
    send(`SRT_COMMA_NEG);
    chk("framed", n + 1, n_low);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_regs();
    t_enc();
    t_bist();
    t_bbist();
    t_tmode();
    finish_test();
  end
endmodule
bind srt_rx_test srt_rx_test_props #(.LOOP_LEN(LOOP_LEN)) u_props (.*);
